/* File: sense_pkg.sv */
// sense responder constants, types and sense code lookup
package sense_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] INJECT_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] INFO_OFS   = 8'h0C;
  localparam logic [7:0] COUNT_OFS  = 8'h10;

  // field positions
  localparam int CTRL_EOM_BIT     = 0;
  localparam int CTRL_DISCARD_BIT = 1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [7:0] SENSE_BYTES   = 8'h12;
  localparam logic [7:0] BYTE0_VALUE   = 8'hF0;
  localparam logic [7:0] ADD_SENSE_LEN = 8'h0A;
  localparam logic [7:0] STATUS_GOOD   = 8'h00;
  localparam logic [7:0] MSG_COMPLETE  = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_LOAD   = 3'b001,
    ST_DATA   = 3'b010,
    ST_STATUS = 3'b011,
    ST_MSG    = 3'b100,
    ST_FREE   = 3'b101
  } phase_type;

  typedef enum logic [3:0] {
    CAUSE_NONE      = 4'h0,
    CAUSE_NOT_READY = 4'h1,
    CAUSE_JAM       = 4'h2,
    CAUSE_COVER     = 4'h3,
    CAUSE_CHUTE     = 4'h4,
    CAUSE_INTERNAL  = 4'h5,
    CAUSE_PARITY    = 4'h6,
    CAUSE_BAD_CMD   = 4'h7,
    CAUSE_BAD_CDB   = 4'h8,
    CAUSE_BAD_LUN   = 4'h9,
    CAUSE_BAD_PARM  = 4'hA,
    CAUSE_UNIT_ATTN = 4'hB,
    CAUSE_ABORTED   = 4'hC
  } cause_type;

  // returns {key[3:0], code[7:0], qualifier[7:0]}
  function automatic logic [19:0] sense_code(input cause_type c);
    unique case (c)
      CAUSE_NONE:      sense_code = 20'h0_00_00;
      CAUSE_NOT_READY: sense_code = 20'h2_00_00;
      CAUSE_JAM:       sense_code = 20'h3_80_01;
      CAUSE_COVER:     sense_code = 20'h3_80_02;
      CAUSE_CHUTE:     sense_code = 20'h3_80_03;
      CAUSE_INTERNAL:  sense_code = 20'h4_44_00;
      CAUSE_PARITY:    sense_code = 20'h4_47_00;
      CAUSE_BAD_CMD:   sense_code = 20'h5_20_00;
      CAUSE_BAD_CDB:   sense_code = 20'h5_24_00;
      CAUSE_BAD_LUN:   sense_code = 20'h5_25_00;
      CAUSE_BAD_PARM:  sense_code = 20'h5_26_00;
      CAUSE_UNIT_ATTN: sense_code = 20'h6_00_00;
      CAUSE_ABORTED:   sense_code = 20'hB_43_00;
      default:         sense_code = 20'h0_00_00;
    endcase
  endfunction : sense_code

endpackage : sense_pkg

/* File: sense_byte_mux.sv */
// selects one byte of the fixed format sense data
`timescale 1ns/10ps
`default_nettype none
module sense_byte_mux
  import sense_pkg::*;
(
  // selection
  input  wire logic [7:0]  byteIdx,
  // held sense content
  input  wire cause_type   cause,
  input  wire logic        eom,
  input  wire logic        ili,
  input  wire logic [31:0] info,
  // result
  output logic      [7:0]  senseByte
);
  wire logic [19:0] code = sense_code(cause);

  always_comb begin
    unique case (byteIdx)
      8'h00: senseByte = BYTE0_VALUE;
      8'h02: senseByte = {1'b0, eom, ili, 1'b0, code[19:16]};
      8'h03: senseByte = info[31:24];
      8'h04: senseByte = info[23:16];
      8'h05: senseByte = info[15:8];
      8'h06: senseByte = info[7:0];
      8'h07: senseByte = ADD_SENSE_LEN;
      8'h0C: senseByte = code[15:8];
      8'h0D: senseByte = code[7:0];
      default: senseByte = 8'h00;
    endcase
  end
endmodule : sense_byte_mux
`default_nettype wire

/* File: sense_responder.sv */
// request sense target: sense assembly, phase sequence, register bus
//
// The AXI4-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module sense_responder
  import sense_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // command from the decoder, one-cycle pulse
  input  wire logic        cmdValid,
  input  wire logic [7:0]  cmdAllocLen,
  // error events from the unit
  input  wire logic        errEvent,
  input  wire cause_type   errCause,
  input  wire logic        lenErrEvent,
  input  wire logic [31:0] reqCount,
  input  wire logic [31:0] actCount,
  // target side bus phase stream
  output phase_type        busPhase,
  output logic             busBusy,
  output logic             byteValid,
  output logic [7:0]       byteData,
  input  wire logic        byteAck,
  // axi4-lite slave
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp
);

  //////////////////////////////////////////////////////////////////////
  // state

  phase_type   stateQ;
  phase_type   stateD;
  logic [7:0]  idxQ;
  logic [7:0]  lenQ;
  logic        validQ;
  logic [7:0]  dataQ;
  logic        busyQ;
  logic [7:0]  lastCountQ;

  cause_type   heldCauseQ;
  logic        heldIliQ;
  logic [31:0] heldInfoQ;
  cause_type   snapCauseQ;
  logic        snapIliQ;
  logic        snapEomQ;
  logic [31:0] snapInfoQ;

  logic        eomQ;
  logic        injectQ;
  cause_type   injectCauseQ;
  logic        discardQ;

  //////////////////////////////////////////////////////////////////////
  // sequence decode

  wire logic       fire     = validQ & byteAck;
  wire logic [7:0] idxNext  = idxQ + 8'h01;
  wire logic       lastByte = (idxNext == lenQ);
  wire logic [7:0] xferLen  = (cmdAllocLen < SENSE_BYTES) ?
                              cmdAllocLen : SENSE_BYTES;
  // the mux looks one byte ahead so byteData stays a flop
  wire logic [7:0] selIdx   = (stateQ == ST_LOAD) ? 8'h00 : idxNext;
  wire logic       delivered = (stateQ == ST_MSG) & fire;
  wire logic [7:0] muxByte;

  sense_byte_mux u_mux (
    .byteIdx   (selIdx),
    .cause     (snapCauseQ),
    .eom       (snapEomQ),
    .ili       (snapIliQ),
    .info      (snapInfoQ),
    .senseByte (muxByte)
  );

  always_comb begin
    stateD = stateQ;
    unique case (stateQ)
      ST_IDLE:   if (cmdValid) begin
        stateD = ST_LOAD;
      end
      ST_LOAD:   stateD = (lenQ == 8'h00) ? ST_STATUS : ST_DATA;
      ST_DATA:   if (fire && lastByte) begin
        stateD = ST_STATUS;
      end
      ST_STATUS: if (fire) begin
        stateD = ST_MSG;
      end
      ST_MSG:    if (fire) begin
        stateD = ST_FREE;
      end
      ST_FREE:   stateD = ST_IDLE;
      default:   stateD = ST_IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // phase sequencer

  // data in, status, message, bus free
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stateQ <= ST_IDLE;
      busyQ  <= 1'b0;
    end else begin
      stateQ <= stateD;
      busyQ  <= (stateD != ST_IDLE) && (stateD != ST_FREE);
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      idxQ   <= 8'h00;
      validQ <= 1'b0;
      dataQ  <= 8'h00;
    end else if (stateQ == ST_LOAD) begin
      idxQ   <= 8'h00;
      validQ <= 1'b1;
      dataQ  <= (lenQ == 8'h00) ? STATUS_GOOD : muxByte;
    end else if (fire) begin
      idxQ   <= idxNext;
      validQ <= (stateQ != ST_MSG);
      unique case (stateQ)
        ST_DATA:   dataQ <= lastByte ? STATUS_GOOD : muxByte;
        ST_STATUS: dataQ <= MSG_COMPLETE;
        default:   dataQ <= 8'h00;
      endcase
    end
  end

  // allocation length from cdb byte 4
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lenQ       <= 8'h00;
      lastCountQ <= 8'h00;
    end else begin
      if (stateQ == ST_IDLE && cmdValid) begin
        lenQ <= xferLen;
      end
      if (delivered) begin
        lastCountQ <= lenQ;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // held error state

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      snapCauseQ <= CAUSE_NONE;
      snapIliQ   <= 1'b0;
      snapEomQ   <= 1'b0;
      snapInfoQ  <= 32'h0000_0000;
    end else if (stateQ == ST_IDLE && cmdValid) begin
      snapCauseQ <= heldCauseQ;
      snapIliQ   <= heldIliQ;
      snapEomQ   <= eomQ;
      snapInfoQ  <= heldIliQ ? heldInfoQ : 32'h0000_0000;
    end
  end

  // a new error in the clearing cycle survives the clear
  wire logic clearHeld = delivered | discardQ;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      heldCauseQ <= CAUSE_UNIT_ATTN;
    end else if (errEvent) begin
      heldCauseQ <= errCause;
    end else if (injectQ) begin
      heldCauseQ <= injectCauseQ;
    end else if (clearHeld) begin
      heldCauseQ <= CAUSE_NONE;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      heldIliQ  <= 1'b0;
      heldInfoQ <= 32'h0000_0000;
    end else if (lenErrEvent) begin
      heldIliQ  <= 1'b1;
      heldInfoQ <= reqCount - actCount;
    end else if (clearHeld) begin
      heldIliQ  <= 1'b0;
      heldInfoQ <= 32'h0000_0000;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // axi4-lite write path

  logic        awreadyQ;
  logic        wreadyQ;
  logic        bvalidQ;
  logic [1:0]  brespQ;
  logic        awHeldQ;
  logic        wHeldQ;
  logic [7:0]  awAddrQ;
  logic [31:0] wDataQ;
  logic [3:0]  wStrbQ;

  wire logic awFire = awvalid & awreadyQ;
  wire logic wFire  = wvalid & wreadyQ;
  wire logic commit = awHeldQ & wHeldQ & ~bvalidQ;
  wire logic wrCtrl = commit & (awAddrQ == CTRL_OFS) & wStrbQ[0];
  wire logic wrInj  = commit & (awAddrQ == INJECT_OFS) & wStrbQ[0];
  wire logic wrMapped = (awAddrQ == CTRL_OFS) ||
                        (awAddrQ == INJECT_OFS) ||
                        (awAddrQ == STATUS_OFS) ||
                        (awAddrQ == INFO_OFS) ||
                        (awAddrQ == COUNT_OFS);

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      awHeldQ <= 1'b0;
      wHeldQ  <= 1'b0;
      awAddrQ <= 8'h00;
      wDataQ  <= 32'h0000_0000;
      wStrbQ  <= 4'h0;
    end else begin
      if (awFire) begin
        awHeldQ <= 1'b1;
        awAddrQ <= awaddr;
      end else if (commit) begin
        awHeldQ <= 1'b0;
      end
      if (wFire) begin
        wHeldQ <= 1'b1;
        wDataQ <= wdata;
        wStrbQ <= wstrb;
      end else if (commit) begin
        wHeldQ <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      awreadyQ <= 1'b0;
      wreadyQ  <= 1'b0;
      bvalidQ  <= 1'b0;
      brespQ   <= RESP_OKAY;
    end else begin
      awreadyQ <= ~(awFire | awHeldQ);
      wreadyQ  <= ~(wFire | wHeldQ);
      if (commit) begin
        bvalidQ <= 1'b1;
        brespQ  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalidQ <= 1'b0;
      end
    end
  end

  // control bits; discard and inject act for one cycle
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      eomQ         <= 1'b0;
      discardQ     <= 1'b0;
      injectQ      <= 1'b0;
      injectCauseQ <= CAUSE_NONE;
    end else begin
      if (wrCtrl) begin
        eomQ <= wDataQ[CTRL_EOM_BIT];
      end
      discardQ <= wrCtrl & wDataQ[CTRL_DISCARD_BIT];
      injectQ  <= wrInj;
      if (wrInj) begin
        injectCauseQ <= cause_type'(wDataQ[3:0]);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // axi4-lite read path

  logic        arreadyQ;
  logic        rvalidQ;
  logic [31:0] rdataQ;
  logic [1:0]  rrespQ;

  wire logic        arFire = arvalid & arreadyQ;
  wire logic [19:0] heldCode = sense_code(heldCauseQ);
  logic [31:0] rdMux;
  logic        rdHit;

  always_comb begin
    rdHit = 1'b1;
    unique case (araddr)
      CTRL_OFS:   rdMux = {30'h0, 1'b0, eomQ};
      INJECT_OFS: rdMux = {28'h0, injectCauseQ};
      STATUS_OFS: rdMux = {3'h0, busyQ, heldIliQ, stateQ,
                           4'h0,
                           heldCode};
      INFO_OFS:   rdMux = heldInfoQ;
      COUNT_OFS:  rdMux = {24'h0, lastCountQ};
      default: begin
        rdMux = 32'h0000_0000;
        rdHit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      arreadyQ <= 1'b0;
      rvalidQ  <= 1'b0;
      rdataQ   <= 32'h0000_0000;
      rrespQ   <= RESP_OKAY;
    end else begin
      arreadyQ <= ~arFire & (~rvalidQ | rready);
      if (arFire) begin
        rvalidQ <= 1'b1;
        rdataQ  <= rdMux;
        rrespQ  <= rdHit ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
        rvalidQ <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs

  assign busPhase  = stateQ;
  assign busBusy   = busyQ;
  assign byteValid = validQ;
  assign byteData  = dataQ;
  assign awready   = awreadyQ;
  assign wready    = wreadyQ;
  assign bvalid    = bvalidQ;
  assign bresp     = brespQ;
  assign arready   = arreadyQ;
  assign rvalid    = rvalidQ;
  assign rdata     = rdataQ;
  assign rresp     = rrespQ;

endmodule : sense_responder
`default_nettype wire

/* File: sense_responder_chk.sv */
// assertions on the phase stream of the request sense responder
`timescale 1ns/10ps
`default_nettype none
module sense_responder_chk
  import sense_pkg::*;
(
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       sys_rst,
  // command and phase stream
  input wire logic       cmdValid,
  input wire logic [7:0] cmdAllocLen,
  input wire phase_type  busPhase,
  input wire logic       busBusy,
  input wire logic       byteValid,
  input wire logic [7:0] byteData,
  input wire logic       byteAck
);
  logic [7:0] limit_q;
  logic [7:0] index_q;
  wire        accept = cmdValid && busPhase == ST_IDLE;
  wire        offer  = busPhase == ST_DATA && byteValid;
  ////////////////////////////////////////////////////////////////////
  // index of the byte on offer and the count it has to reach
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      limit_q <= 8'h00;
      index_q <= 8'h00;
    end else if (accept) begin
      limit_q <= (cmdAllocLen < SENSE_BYTES) ? cmdAllocLen : SENSE_BYTES;
      index_q <= 8'h00;
    end else if (offer && byteAck) begin
      index_q <= index_q + 8'h01;
    end
  end
  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence msgTaken;
    busPhase == ST_MSG && byteValid && byteAck;
  endsequence
  sequence busFreed;
    ##1 (busPhase == ST_FREE && !busBusy && !byteValid)
    ##1 busPhase == ST_IDLE;
  endsequence
  a_load_on_cmd: assert property (
    accept |=> busPhase == ST_LOAD && busBusy)
    else $error("no load phase after command");
  a_zero_alloc: assert property (
    accept && cmdAllocLen == 8'h00 |=> ##1 busPhase == ST_STATUS)
    else $error("zero length did not skip data");
  a_data_count: assert property (
    busPhase == ST_STATUS && $past(busPhase) == ST_DATA |-> index_q == limit_q)
    else $error("wrong number of sense bytes");
  a_byte_zero: assert property (
    offer && index_q == 8'h00 |-> byteData == BYTE0_VALUE)
    else $error("first sense byte wrong");
  a_fixed_zero: assert property (
    offer && (index_q == 8'h01 || (index_q >= 8'h08 && index_q <= 8'h0B))
    |-> byteData == 8'h00)
    else $error("fixed zero byte not zero");
  a_mark_clear: assert property (
    offer && index_q == 8'h02 |-> !byteData[7] && !byteData[4])
    else $error("file mark bit set");
  a_add_length: assert property (
    offer && index_q == 8'h07 |-> byteData == ADD_SENSE_LEN)
    else $error("additional length wrong");
  a_hold_byte: assert property (
    byteValid && !byteAck |=> byteValid && $stable(byteData))
    else $error("offered byte changed before ack");
  a_status_msg: assert property (
    busPhase == ST_STATUS && byteValid |-> byteData == STATUS_GOOD)
    else $error("status byte not good");
  a_msg_byte: assert property (
    busPhase == ST_MSG && byteValid |-> byteData == MSG_COMPLETE)
    else $error("message byte not command complete");
  a_msg_free: assert property (
    msgTaken |-> busFreed)
    else $error("bus not freed after message");
endmodule : sense_responder_chk

bind sense_responder sense_responder_chk chk (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .cmdValid(cmdValid),
  .cmdAllocLen(cmdAllocLen), .busPhase(busPhase), .busBusy(busBusy),
  .byteValid(byteValid), .byteData(byteData), .byteAck(byteAck)
);
`default_nettype wire

/* File: sense_initiator_model.sv */
// initiator model: accepts phase bytes and keeps what it received
`timescale 1ns/10ps
`default_nettype none
module sense_initiator_model
  import sense_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  // bench controls
  input  wire logic       slow,
  input  wire logic       cmdValid,
  // target phase stream
  input  wire phase_type  busPhase,
  input  wire logic       byteValid,
  input  wire logic [7:0] byteData,
  output logic            byteAck
);
  logic [7:0] got_q [0:17];
  logic [7:0] dataCnt_q;
  logic [7:0] status_q;
  logic [7:0] message_q;
  logic [1:0] wait_q;
  wire        pending = byteValid && !byteAck;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      byteAck   <= 1'b0;
      wait_q    <= 2'h0;
      dataCnt_q <= 8'h00;
      status_q  <= 8'hFF;
      message_q <= 8'hFF;
    end else begin
      // slow mode stalls each byte two extra cycles
      byteAck <= pending && (!slow || wait_q == 2'h2);
      wait_q  <= (pending && wait_q != 2'h2) ? wait_q + 2'h1 : 2'h0;
      // a new command descriptor starts a fresh capture
      if (cmdValid) begin
        dataCnt_q <= 8'h00;
        status_q  <= 8'hFF;
        message_q <= 8'hFF;
      end
      if (byteValid && byteAck && busPhase == ST_DATA) begin
        if (dataCnt_q < 8'h12) got_q[dataCnt_q[4:0]] <= byteData;
        dataCnt_q <= dataCnt_q + 8'h01;
      end
      if (byteValid && byteAck && busPhase == ST_STATUS) status_q <= byteData;
      if (byteValid && byteAck && busPhase == ST_MSG) message_q <= byteData;
    end
  end
endmodule : sense_initiator_model
`default_nettype wire

/* File: sense_responder_tb_top.sv */
// self-checking bench for the request sense responder
`timescale 1ns/10ps
`default_nettype none
module sense_responder_tb_top;
  import sense_pkg::*;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        cmdValid = 1'b0, errEvent = 1'b0, lenErrEvent = 1'b0;
  logic        slow = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  cmdAllocLen = 8'h00, awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] reqCount = 32'h0, actCount = 32'h0, wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  cause_type   errCause = CAUSE_NONE;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        byteValid, byteAck, busBusy;
  logic [1:0]  bresp, rresp;
  logic [7:0]  byteData;
  logic [31:0] rdata;
  phase_type   busPhase;
  int          bad_count = 0;
  int          checked = 0;
  logic [19:0] codes [13] = '{20'h0_00_00, 20'h2_00_00, 20'h3_80_01,
    20'h3_80_02, 20'h3_80_03, 20'h4_44_00, 20'h4_47_00, 20'h5_20_00,
    20'h5_24_00, 20'h5_25_00, 20'h5_26_00, 20'h6_00_00, 20'hB_43_00};
  always #5 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////
  sense_responder dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .cmdValid(cmdValid),
    .cmdAllocLen(cmdAllocLen), .errEvent(errEvent), .errCause(errCause),
    .lenErrEvent(lenErrEvent), .reqCount(reqCount), .actCount(actCount),
    .busPhase(busPhase), .busBusy(busBusy), .byteValid(byteValid),
    .byteData(byteData), .byteAck(byteAck), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
  sense_initiator_model ini (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .slow(slow), .cmdValid(cmdValid),
    .busPhase(busPhase), .byteValid(byteValid), .byteData(byteData),
    .byteAck(byteAck));
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  // readies are flops, so the level at the falling edge is what the
  // next rising edge takes
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    while (aw || w) begin
      @(negedge ref_clk);
      if (awready === 1'b1) aw = 1'b0;
      if (wready === 1'b1) w = 1'b0;
      @(posedge ref_clk);
      if (!aw) awvalid <= 1'b0;
      if (!w) wvalid <= 1'b0;
    end
    bready <= 1'b1;
    do @(negedge ref_clk); while (bvalid !== 1'b1);
    chk("bresp", 32'(RESP_OKAY), 32'(bresp));
    @(posedge ref_clk);
    bready <= 1'b0;
  endtask : axi_write
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    arvalid <= 1'b1;
    araddr <= a;
    do @(negedge ref_clk); while (arready !== 1'b1);
    @(posedge ref_clk);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(negedge ref_clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    @(posedge ref_clk);
    rready <= 1'b0;
  endtask : axi_read
  task automatic pulse_err(input cause_type c);
    errEvent <= 1'b1;
    errCause <= c;
    @(posedge ref_clk);
    errEvent <= 1'b0;
  endtask : pulse_err
  // a command goes out only while the target is idle
  task automatic request(input logic [7:0] len);
    do @(negedge ref_clk); while (busPhase !== ST_IDLE);
    @(posedge ref_clk);
    cmdValid <= 1'b1;
    cmdAllocLen <= len;
    @(posedge ref_clk);
    cmdValid <= 1'b0;
    do @(negedge ref_clk); while (busPhase !== ST_IDLE);
    @(posedge ref_clk);
  endtask : request
  // bytes E onward are reserved and left unchecked
  task automatic sense_run(input logic [7:0] len, input logic [19:0] kcq,
                           input logic eom, input logic ili,
                           input logic [31:0] info);
    logic [7:0] e [14];
    int n;
    e = '{BYTE0_VALUE, 8'h00, {1'b0, eom, ili, 1'b0, kcq[19:16]},
      info[31:24], info[23:16], info[15:8], info[7:0], ADD_SENSE_LEN,
      8'h00, 8'h00, 8'h00, 8'h00, kcq[15:8], kcq[7:0]};
    n = (len < SENSE_BYTES) ? int'(len) : 18;
    request(len);
    chk("sense count", 32'(n), 32'(ini.dataCnt_q));
    for (int i = 0; i < n && i < 14; i++) begin
      chk("sense byte", 32'(e[i]), 32'(ini.got_q[i]));
    end
    chk("status byte", 32'(STATUS_GOOD), 32'(ini.status_q));
    chk("message byte", 32'(MSG_COMPLETE), 32'(ini.message_q));
  endtask : sense_run
  ////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    sense_run(8'h12, 20'h6_00_00, 1'b0, 1'b0, 32'h0);
    sense_run(8'h12, 20'h0_00_00, 1'b0, 1'b0, 32'h0);
    for (int i = 1; i < 13; i++) begin
      slow <= i[0];
      axi_write(INJECT_OFS, 32'(i));
      axi_read(STATUS_OFS, d, r);
      chk("status reg", {12'h000, codes[i]}, d);
      chk("status resp", 32'(RESP_OKAY), 32'(r));
      sense_run(8'h12, codes[i], 1'b0, 1'b0, 32'h0);
    end
    pulse_err(CAUSE_JAM);
    sense_run(8'h05, 20'h3_80_01, 1'b0, 1'b0, 32'h0);
    axi_read(COUNT_OFS, d, r);
    chk("count reg", 32'h5, d);
    axi_write(CTRL_OFS, 32'h1);
    lenErrEvent <= 1'b1;
    reqCount <= 32'hA;
    actCount <= 32'hE;
    @(posedge ref_clk);
    lenErrEvent <= 1'b0;
    sense_run(8'h12, 20'h0_00_00, 1'b1, 1'b1, 32'hFFFF_FFFC);
    axi_write(CTRL_OFS, 32'h0);
    pulse_err(CAUSE_PARITY);
    sense_run(8'h00, 20'h4_47_00, 1'b0, 1'b0, 32'h0);
    axi_write(INJECT_OFS, 32'(CAUSE_COVER));
    axi_write(CTRL_OFS, 32'h2);
    sense_run(8'h12, 20'h0_00_00, 1'b0, 1'b0, 32'h0);
    // a reset between runs, with the target idle, must bring unit attention back
    sys_rst <= 1'b1;
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    sense_run(8'h12, 20'h6_00_00, 1'b0, 1'b0, 32'h0);
    axi_read(8'h14, d, r);
    chk("unmapped resp", 32'(RESP_SLVERR), 32'(r));
    chk("unmapped data", 32'h0, d);
    tally_and_finish();
  end
  // the run needs under two thousand cycles; this cuts a hang short
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    tally_and_finish();
  end
endmodule : sense_responder_tb_top
`default_nettype wire
